/* hdl/rwdt_pkg.sv */
// constants, register map and carrier types of the runaway watchdog timer
// assumes a 125 MHz system clock and an AXI4-Lite register slave
package rwdt_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] RWDT_MODE_OFF = 12'h000; // mode register
	localparam logic [11:0] RWDT_CMD_OFF = 12'h004; // command register
	localparam logic [11:0] RWDT_PERM_OFF = 12'h008; // write permission flag
	localparam logic [11:0] RWDT_IRQ_STAT_OFF = 12'h00C; // sticky event status
	localparam logic [11:0] RWDT_IRQ_MASK_OFF = 12'h010; // event mask
	// field positions
	localparam int RWDT_EN_BIT = 7;
	localparam int RWDT_TIME_LSB = 4;
	localparam int RWDT_ACT_BIT = 1;
	localparam int RWDT_RSVD_BIT = 2;
	// reset values
	localparam logic RWDT_EN_RST = 1'h1;
	localparam logic RWDT_ACT_RST = 1'h1;
	localparam logic [2:0] RWDT_TIME_RST = 3'h0;
	// command codes
	localparam logic [7:0] RWDT_CODE_DISABLE = 8'hB1;
	localparam logic [7:0] RWDT_CODE_CLEAR = 8'h4E;
	// timing
	localparam int RWDT_CNT_W = 25; // counter width, longest time 2^25
	localparam int RWDT_RST_STATES = 32; // internal reset length in states
	localparam logic [5:0] RWDT_RST_CYC = 6'(RWDT_RST_STATES);
	// status bit positions
	localparam int RWDT_EV_OVF = 0; // overflow seen
	localparam int RWDT_EV_BADCMD = 1; // reserved code or refused write
	localparam int RWDT_EV_N = 2;
	// axi responses
	localparam logic [1:0] RWDT_RESP_OKAY = 2'h0;
	localparam logic [1:0] RWDT_RESP_SLVERR = 2'h2;

	// one axi write request taken from the bus
	typedef struct packed
	{
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} rwdt_wreq_type;

	// mode register contents
	typedef struct packed
	{
		logic enable;
		logic [2:0] time_sel;
		logic rsvd;
		logic action;
	} rwdt_mode_type;
endpackage

/* hdl/rwdt_counter.sv */
// binary counter and overflow detector of the runaway watchdog timer
// assumes clear and run are synchronous to clk
`timescale 1ns/100ps
module rwdt_counter import rwdt_pkg::*;
#(
	parameter int CNT_W = RWDT_CNT_W
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic clear,
	input wire logic [2:0] time_sel,
	output logic overflow
);
	// ****************************************
	// counter
	// ****************************************
	logic [CNT_W-1:0] count_q; // binary count, advances only while run is high
	logic [CNT_W-1:0] limit; // last count before overflow
	logic tc_hit; // count reached its selected limit

	// detection time 2^(15+2*sel); reserved codes fall back to the longest
	always_comb
	begin
		unique case (time_sel)
			3'h0: limit = CNT_W'((1 << 15) - 1);
			3'h1: limit = CNT_W'((1 << 17) - 1);
			3'h2: limit = CNT_W'((1 << 19) - 1);
			3'h3: limit = CNT_W'((1 << 21) - 1);
			3'h4: limit = CNT_W'((1 << 23) - 1);
			default: limit = {CNT_W{1'b1}};
		endcase
	end

	assign tc_hit = (count_q == limit);

	// clear wins over counting; wraps after overflow so it repeats
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= '0;
		else if (clear)
			count_q <= '0;
		else if (run)
			count_q <= tc_hit ? '0 : count_q + 1'b1;
	end

	// one-cycle overflow pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			overflow <= 1'b0;
		else
			overflow <= run && !clear && tc_hit;
	end

	// ****************************************
	// checks
	// ****************************************
	clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		clear |=> count_q == '0)
		else $error("counter not zero after clear");
	ovf_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
		overflow |-> $past(tc_hit) && $past(run))
		else $error("overflow without reaching limit");
endmodule

/* hdl/rwdt_top.sv */
// runaway watchdog timer: registers on axi4-lite, nmi, reset and notify pin
// assumes one 125 MHz clock and an axi master with one transfer per channel
`timescale 1ns/100ps
module rwdt_top import rwdt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// watchdog outputs
	output logic watchdog_nmi_request,
	output logic wdt_reset_req,
	output logic runaway_notify_pin_n,
	output logic irq
);
	// ****************************************
	// state
	// ****************************************
	rwdt_mode_type mode_q; // mode register
	logic running_q; // counter actually enabled
	logic write_blocked_flag_q; // writes other than status and mask refused while set
	logic [RWDT_EV_N-1:0] stat_q; // sticky events
	logic [RWDT_EV_N-1:0] mask_q; // event enables
	logic [5:0] rst_cnt_q; // internal reset length counter
	logic aw_have_q; // address latched
	logic w_have_q; // data latched
	rwdt_wreq_type wreq_q; // latched write request
	logic overflow; // pulse from counter
	logic do_write; // write takes effect this cycle
	logic cmd_clear; // clear code accepted
	logic cmd_disable; // disable code accepted
	logic cmd_bad; // refused or reserved access
	logic wr_ok; // write permitted
	logic [31:0] rd_word; // read mux
	logic rd_err; // unmapped read
	logic [RWDT_EV_N-1:0] ev; // events this cycle

	// ****************************************
	// axi write path
	// ****************************************
	// address and data accepted in either order, held until response drains
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			wreq_q <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				wreq_q.addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wreq_q.data <= s_axi_wdata;
				wreq_q.strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
		end
	end

	// ready only while the slot is free and no response waits
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid && !do_write;
			s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid && !do_write;
		end
	end

	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	// the flag only blocks while the internal reset is under way
	assign wr_ok = !write_blocked_flag_q;

	// command decode; reserved codes only raise cmd_bad
	always_comb
	begin
		cmd_clear = 1'b0;
		cmd_disable = 1'b0;
		cmd_bad = 1'b0;
		if (do_write)
		begin
			if (!wr_ok && wreq_q.addr != RWDT_IRQ_STAT_OFF && wreq_q.addr != RWDT_IRQ_MASK_OFF)
				cmd_bad = 1'b1;
			else if (wreq_q.addr == RWDT_CMD_OFF && wreq_q.strb[0])
			begin
				if (wreq_q.data[7:0] == RWDT_CODE_CLEAR)
					cmd_clear = 1'b1;
				else if (wreq_q.data[7:0] == RWDT_CODE_DISABLE)
					cmd_disable = 1'b1;
				else
					cmd_bad = 1'b1;
			end
		end
	end

	// write response: slverr for addresses other than mode, command, status and mask; refused writes still answer okay
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RWDT_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			if (wreq_q.addr == RWDT_MODE_OFF || wreq_q.addr == RWDT_CMD_OFF
				|| wreq_q.addr == RWDT_IRQ_STAT_OFF || wreq_q.addr == RWDT_IRQ_MASK_OFF)
				s_axi_bresp <= RWDT_RESP_OKAY;
			else
				s_axi_bresp <= RWDT_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ****************************************
	// mode register and enable sequence
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q.enable <= RWDT_EN_RST;
			mode_q.time_sel <= RWDT_TIME_RST;
			mode_q.rsvd <= 1'b0;
			mode_q.action <= RWDT_ACT_RST;
		end
		else if (do_write && wr_ok && wreq_q.addr == RWDT_MODE_OFF && wreq_q.strb[0])
		begin
			mode_q.enable <= wreq_q.data[RWDT_EN_BIT];
			mode_q.time_sel <= wreq_q.data[RWDT_TIME_LSB +: 3];
			mode_q.rsvd <= wreq_q.data[RWDT_RSVD_BIT];
			mode_q.action <= wreq_q.data[RWDT_ACT_BIT];
		end
	end

	// stops only on disable code after enable bit cleared; resumes on bit set
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			running_q <= 1'b1;
		else if (mode_q.enable)
			running_q <= 1'b1;
		else if (cmd_disable)
			running_q <= 1'b0;
	end

	// ****************************************
	// counter
	// ****************************************
	rwdt_counter #(.CNT_W(RWDT_CNT_W)) u_counter
	(
		.clk(clk),
		.rst_n(rst_n),
		.run(running_q),
		.clear(cmd_clear || (cmd_disable && !mode_q.enable)),
		.time_sel(mode_q.time_sel),
		.overflow(overflow)
	);

	// ****************************************
	// runaway response
	// ****************************************
	// nmi level held until the clear code or an overflow with the reset action; the pin goes low on every overflow, reset action included
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			watchdog_nmi_request <= 1'b0;
			runaway_notify_pin_n <= 1'b1;
		end
		else
		begin
			if (overflow)
			begin
				watchdog_nmi_request <= !mode_q.action;
				runaway_notify_pin_n <= 1'b0;
			end
			else if (cmd_clear)
			begin
				watchdog_nmi_request <= 1'b0;
				runaway_notify_pin_n <= 1'b1;
			end
		end
	end

	// internal reset pulse, 32 cycles, writes other than status and mask refused meanwhile
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_cnt_q <= '0;
			wdt_reset_req <= 1'b0;
			write_blocked_flag_q <= 1'b0;
		end
		else
		begin
			if (overflow && mode_q.action)
				rst_cnt_q <= RWDT_RST_CYC;
			else if (rst_cnt_q != '0)
				rst_cnt_q <= rst_cnt_q - 1'b1;
			wdt_reset_req <= (overflow && mode_q.action) || rst_cnt_q > 6'h1;
			write_blocked_flag_q <= (overflow && mode_q.action) || rst_cnt_q > 6'h1;
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	assign ev[RWDT_EV_OVF] = overflow;
	assign ev[RWDT_EV_BADCMD] = cmd_bad;

	// set wins over write-one-to-clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stat_q <= '0;
		else if (do_write && wreq_q.addr == RWDT_IRQ_STAT_OFF && wreq_q.strb[0])
			stat_q <= (stat_q & ~wreq_q.data[RWDT_EV_N-1:0]) | ev;
		else
			stat_q <= stat_q | ev;
	end

	// mask register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_q <= '0;
		else if (do_write && wreq_q.addr == RWDT_IRQ_MASK_OFF && wreq_q.strb[0])
			mask_q <= wreq_q.data[RWDT_EV_N-1:0];
	end

	// level interrupt
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |((stat_q | ev) & mask_q);
	end

	// ****************************************
	// axi read path
	// ****************************************
	always_comb
	begin
		rd_word = '0;
		rd_err = 1'b0;
		unique case (s_axi_araddr)
			RWDT_MODE_OFF: rd_word = {24'h0, mode_q.enable, mode_q.time_sel, 1'b0,
				mode_q.rsvd, mode_q.action, 1'b0};
			RWDT_CMD_OFF: rd_word = '0; // write-only
			RWDT_PERM_OFF: rd_word = {31'h0, write_blocked_flag_q};
			RWDT_IRQ_STAT_OFF: rd_word = {30'h0, stat_q};
			RWDT_IRQ_MASK_OFF: rd_word = {30'h0, mask_q};
			default: rd_err = 1'b1;
		endcase
	end

	// one read at a time, data one cycle after the address handshake
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RWDT_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_err ? RWDT_RESP_SLVERR : RWDT_RESP_OKAY;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence reset_run_s;
		wdt_reset_req [*8];
	endsequence

	nmi_path_a: assert property (@(posedge clk) disable iff (!rst_n)
		overflow && !mode_q.action |=> watchdog_nmi_request && !wdt_reset_req)
		else $error("nmi not raised for interrupt action");
	pin_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		overflow |=> !runaway_notify_pin_n)
		else $error("notify pin not low on overflow");
	reset_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		overflow && mode_q.action |=> reset_run_s ##0 (rst_cnt_q == 6'd25))
		else $error("internal reset too short");
	reset_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(wdt_reset_req) |-> $past(rst_cnt_q) == 6'h1)
		else $error("internal reset wrong length");
	enable_rst_a: assert property (@(posedge clk)
		$rose(rst_n) |-> mode_q.enable && mode_q.action && running_q)
		else $error("mode reset value wrong");
	disable_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(running_q) |-> $past(cmd_disable) && !$past(mode_q.enable))
		else $error("stopped without disable sequence");
	resume_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q.enable |=> running_q)
		else $error("enable bit did not resume");
	pin_high_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_clear && !overflow |=> runaway_notify_pin_n && !watchdog_nmi_request)
		else $error("clear code did not release pin");
	blocked_a: assert property (@(posedge clk) disable iff (!rst_n)
		wdt_reset_req |-> write_blocked_flag_q)
		else $error("flag clear during reset");
	reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_bad |=> running_q == $past(running_q))
		else $error("reserved code changed enable");
	code_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_clear |-> wreq_q.data[7:0] == RWDT_CODE_CLEAR && wreq_q.addr == RWDT_CMD_OFF)
		else $error("clear decoded from wrong code");
endmodule

/* verification/rwdt_bench.sv */
// self-checking bench of the runaway watchdog timer, driven over axi4-lite
// assumes the top module alone, one 125 MHz clock and no partner model
`timescale 1ns/100ps
module rwdt_bench import rwdt_pkg::*;
;
	// ****************************************
	// clock, reset and bus signals
	// ****************************************
	logic clk = 1'b0; // system clock, 8 ns
	logic rst_n = 1'b0; // active low reset
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic watchdog_nmi_request;
	logic wdt_reset_req;
	logic runaway_notify_pin_n;
	logic irq;
	int bad_count = 0; // mismatches seen
	int check_count = 0; // comparisons made
	int cyc = 0; // free running cycle count
	int rst_len = 0; // cycles with reset request high
	int t0; // cycle of the last counter restart
	logic [1:0] resp; // last bus response
	logic [31:0] rdat; // last read data

	always #4 clk = ~clk;

	// cycle stamps, used to time the overflow from a clear or a resume
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (wdt_reset_req === 1'b1)
			rst_len <= rst_len + 1;
	end

	rwdt_top i_rwdt_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .watchdog_nmi_request(watchdog_nmi_request),
		.wdt_reset_req(wdt_reset_req), .runaway_notify_pin_n(runaway_notify_pin_n),
		.irq(irq));

	// ****************************************
	// checking and bus tasks
	// ****************************************
	// one comparison, four-state exact
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a stuck handshake counts as a mismatch
	task automatic stuck(input int n);
		if (n >= 50)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: bus handshake stuck", $time);
		end
	endtask

	// address and data offered together, each released when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic aw_ok;
		logic w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 50)
		begin
			@(posedge clk);
			n++;
			if (!aw_ok && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		stuck(n);
	endtask

	// read one word, rready held until rvalid is sampled
	task automatic axi_rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// let an edge pass first: arready seen in the launch step is not a handshake
		do
		begin
			@(posedge clk);
			n++;
		end
		while (s_axi_arready !== 1'b1 && n < 50);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		stuck(n);
	endtask

	// bounded wait for nmi (sel 1) or reset request (sel 0)
	task automatic wait_hi(input logic sel);
		int n;
		n = 0;
		while ((sel ? watchdog_nmi_request : wdt_reset_req) !== 1'b1 && n < 40000)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	// single exit of the run
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************
	// watchdog of the bench, about 99k cycles expected
	// ****************************************
	initial
	begin
		repeat (110000) @(posedge clk);
		bad_count++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		print_verdict();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// reset state of registers and pins
		axi_rd(RWDT_MODE_OFF);
		chk(rdat, 32'h00000082);
		axi_rd(RWDT_PERM_OFF);
		chk(rdat, 32'h00000000);
		chk({31'h0, runaway_notify_pin_n}, 32'h00000001);
		axi_rd(12'h020);
		chk({30'h0, resp}, {30'h0, RWDT_RESP_SLVERR});
		chk(rdat, 32'h00000000);
		// every detection time code is stored
		for (int k = 0; k < 8; k++)
		begin
			axi_wr(RWDT_MODE_OFF, 32'h00000082 | (k << RWDT_TIME_LSB));
			axi_rd(RWDT_MODE_OFF);
			chk(rdat, 32'h00000082 | (k << RWDT_TIME_LSB));
		end
		axi_wr(RWDT_MODE_OFF, 32'h00000082);
		// disable code before the enable bit is cleared must not stop the counter
		axi_wr(RWDT_CMD_OFF, 32'h000000B1);
		axi_wr(RWDT_MODE_OFF, 32'h00000000);
		axi_wr(RWDT_IRQ_MASK_OFF, 32'h00000003);
		axi_wr(RWDT_CMD_OFF, 32'h0000004E);
		t0 = cyc;
		// reserved code changes neither counter nor enable, flags a bad write
		axi_wr(RWDT_CMD_OFF, 32'h00000055);
		axi_rd(RWDT_IRQ_STAT_OFF);
		chk(rdat, 32'h00000002);
		chk({31'h0, irq}, 32'h00000001);
		axi_wr(RWDT_IRQ_STAT_OFF, 32'h00000002);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		// overflow after 2^15 cycles with the nmi action
		wait_hi(1'b1);
		chk(32'((cyc - t0) >= 32755 && (cyc - t0) <= 32772), 32'h00000001);
		repeat (2) @(posedge clk);
		chk({31'h0, watchdog_nmi_request}, 32'h00000001);
		chk({31'h0, wdt_reset_req}, 32'h00000000);
		chk({31'h0, runaway_notify_pin_n}, 32'h00000000);
		chk({31'h0, irq}, 32'h00000001);
		axi_wr(RWDT_IRQ_MASK_OFF, 32'h00000000);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		axi_wr(RWDT_IRQ_MASK_OFF, 32'h00000001);
		// clear code releases the pin and the request
		axi_wr(RWDT_CMD_OFF, 32'h0000004E);
		repeat (2) @(posedge clk);
		chk({31'h0, runaway_notify_pin_n}, 32'h00000001);
		chk({31'h0, watchdog_nmi_request}, 32'h00000000);
		axi_wr(RWDT_IRQ_STAT_OFF, 32'h00000001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		// proper order: enable already cleared, then disable code
		axi_wr(RWDT_CMD_OFF, 32'h000000B1);
		repeat (33000) @(posedge clk);
		chk({31'h0, watchdog_nmi_request}, 32'h00000000);
		chk({31'h0, runaway_notify_pin_n}, 32'h00000001);
		// enable bit alone resumes, reset action now
		axi_wr(RWDT_MODE_OFF, 32'h00000082);
		t0 = cyc;
		rst_len = 0;
		wait_hi(1'b0);
		chk(32'((cyc - t0) >= 32755 && (cyc - t0) <= 32772), 32'h00000001);
		// writes refused while the internal reset runs
		axi_rd(RWDT_PERM_OFF);
		chk(rdat, 32'h00000001);
		chk({31'h0, watchdog_nmi_request}, 32'h00000000);
		chk({31'h0, runaway_notify_pin_n}, 32'h00000000);
		axi_wr(RWDT_MODE_OFF, 32'h00000000);
		chk({30'h0, resp}, {30'h0, RWDT_RESP_OKAY});
		repeat (40) @(posedge clk);
		chk(32'(rst_len), 32'd32);
		axi_rd(RWDT_MODE_OFF);
		chk(rdat, 32'h00000082);
		axi_rd(RWDT_PERM_OFF);
		chk(rdat, 32'h00000000);
		axi_rd(RWDT_IRQ_STAT_OFF);
		chk(rdat, 32'h00000003);
		print_verdict();
	end
endmodule
